// [scrl_defines.vh]
// Constants and register map of the synchrocheck release logic
// How it works
// - Slip is absolute bus minus line frequency
// - Synchronous only when all three limits hold
// - Mode selects grid or machine checking
// - Machine mode uses breaker closing time
// - Machine mode releases early by slip lead
// - Grid mode: same checks, no compensation
// - Bus from channels one-three, line fourth
// - Supervise manual, automatic or both closes
// - Enabled dead/live overrides release closing
// - External bypass releases regardless of check
`ifndef SCRL_DEFINES_VH
`define SCRL_DEFINES_VH
`define SCRL_ADDR_CTRL      4'h0
`define SCRL_ADDR_DV_LIM    4'h1
`define SCRL_ADDR_DF_LIM    4'h2
`define SCRL_ADDR_DP_LIM    4'h3
`define SCRL_ADDR_CLOSE_T   4'h4
`define SCRL_ADDR_LIVE_LIM  4'h5
`define SCRL_ADDR_DEAD_LIM  4'h6
`define SCRL_ADDR_STATUS    4'h7
`define SCRL_ADDR_IRQ_STAT  4'h8
`define SCRL_ADDR_IRQ_MASK  4'h9
`define SCRL_CTRL_EN        0
`define SCRL_CTRL_MODE      1
`define SCRL_CTRL_SUP_MAN   2
`define SCRL_CTRL_SUP_AUTO  3
`define SCRL_CTRL_LIVE_BUS_DEAD_LINE_EN   4
`define SCRL_CTRL_DEAD_BUS_LIVE_LINE_EN   5
`define SCRL_CTRL_DEAD_BUS_DEAD_LINE_EN   6
`define SCRL_CTRL_PH_LSB    7
`define SCRL_CTRL_RESET     16'h0000
`define SCRL_EVT_SYNC       0
`define SCRL_EVT_RELEASE    1
`define SCRL_EVT_BYPASS     2
`define SCRL_EVT_OVERRIDE   3
`endif

// [scrl_line.sv]
// Line side measuring channel model
`timescale 1ns/1ps
module scrl_line (
	input logic [15:0]	v,
	input logic [15:0]	f,
	input logic [15:0]	a,
	output logic [15:0]	lv,
	output logic [15:0]	lf,
	output logic [15:0]	la
);
	assign {lv, lf, la} = {v, f, a};
endmodule

// [scrl_props.sv]
// Port level checker for the synchrocheck release block
`timescale 1ns/1ps
module scrl_props (
	input logic		clk,
	input logic		rst_b,
	input logic [3:0]	reg_addr,
	input logic [15:0]	reg_wdata,
	input logic		reg_wr,
	input logic [15:0]	bus_mag0,
	input logic [15:0]	bus_ang0,
	input logic [15:0]	bus_freq,
	input logic [15:0]	line_side_voltage,
	input logic [15:0]	line_ang,
	input logic [15:0]	line_freq,
	input logic		manual_close_req,
	input logic		auto_close_req,
	input logic		ext_bypass_pin,
	input logic		close_release,
	input logic		sync_ok
);
	logic [15:0] r_ff [0:6];
	// Shadow of the setting registers; phase checks hold for phase 0 only
	always @(posedge clk or negedge rst_b)
		if (!rst_b) r_ff <= '{0, 0, 0, 0, 0, 16'hffff, 0};
		else if (reg_wr && reg_addr < 4'h7) r_ff[reg_addr] <= reg_wdata;
	wire [15:0] fd = bus_freq - line_freq;
	wire [15:0] vd = bus_mag0 - line_side_voltage;
	wire [15:0] ad = bus_ang0 - line_ang;
	wire ph = |r_ff[0][8:7];
	wire f_ok = fd <= r_ff[2] || 16'h0000 - fd <= r_ff[2];
	wire v_ok = ph || vd <= r_ff[1] || 16'h0000 - vd <= r_ff[1];
	wire a_ok = ph || r_ff[0][1] || ad <= r_ff[3] || 16'h0000 - ad <= r_ff[3];
	wire dead = !ph && bus_mag0 <= r_ff[6] && line_side_voltage <= r_ff[6];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_byp; ext_bypass_pin [*6] |=> close_release; endproperty
	a_byp: assert property (p_byp) else $error("bypass");
	property p_idle; (!ext_bypass_pin) [*6] ##0 !(manual_close_req || auto_close_req) |=> !close_release; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_man; manual_close_req && !r_ff[0][2] |=> close_release; endproperty
	a_man: assert property (p_man) else $error("manual");
	property p_aut; auto_close_req && !r_ff[0][3] |=> close_release; endproperty
	a_aut: assert property (p_aut) else $error("auto");
	property p_slip; sync_ok |-> $past(f_ok); endproperty
	a_slip: assert property (p_slip) else $error("slip");
	property p_mag; sync_ok |-> $past(v_ok); endproperty
	a_mag: assert property (p_mag) else $error("magnitude");
	property p_ang; sync_ok |-> $past(a_ok); endproperty
	a_ang: assert property (p_ang) else $error("angle");
	property p_dead_bus_dead_line; manual_close_req && r_ff[0][2] && r_ff[0][6] && dead |=> close_release; endproperty
	a_dead_bus_dead_line: assert property (p_dead_bus_dead_line) else $error("dead");
endmodule
bind scrl_top scrl_props u_props (.*);

// [scrl_top.v]
// Synchrocheck breaker close release with register port
`timescale 1ns/1ps
`include "scrl_defines.vh"
module scrl_top #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [3:0]   reg_addr,
	input  wire [15:0]  reg_wdata,
	input  wire         reg_wr,
	input  wire         reg_rd,
	output reg  [15:0]  reg_rdata,
	input  wire [W-1:0] bus_mag0,
	input  wire [W-1:0] bus_mag1,
	input  wire [W-1:0] bus_mag2,
	input  wire [W-1:0] bus_ang0,
	input  wire [W-1:0] bus_ang1,
	input  wire [W-1:0] bus_ang2,
	input  wire [W-1:0] bus_freq,
	input  wire [W-1:0] line_side_voltage,
	input  wire [W-1:0] line_ang,
	input  wire [W-1:0] line_freq,
	input  wire         manual_close_req,
	input  wire         auto_close_req,
	input  wire         ext_bypass_pin,
	output reg          close_release,
	output reg          sync_ok,
	output wire         irq
);
	reg  [1:0]   rst_sync_ff;
	wire         rst_n = rst_sync_ff[1];
	reg  [15:0]  ctrl_ff, dv_lim_ff, df_lim_ff, dp_lim_ff, close_t_ff, live_lim_ff, dead_lim_ff;
	reg  [3:0]   irq_stat_ff, irq_mask_ff;
	reg  [2:0]   byp_ff;
	reg          byp_st_ff;
	reg          sync_prev_ff, rel_prev_ff, byp_prev_ff, ovr_prev_ff;
	reg  [W-1:0] bmag, bang;
	wire         mode_mach = ctrl_ff[`SCRL_CTRL_MODE];
	wire [1:0]   ph_sel = ctrl_ff[`SCRL_CTRL_PH_LSB+1:`SCRL_CTRL_PH_LSB];

	function [W-1:0] absdiff;
		input [W-1:0] a;
		input [W-1:0] b;
		begin
			absdiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rst_sync_ff <= 2'b00;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	// Bus phase chosen for comparison with the fourth channel
	always @* begin
		case (ph_sel)
		2'd1: begin bmag = bus_mag1; bang = bus_ang1; end
		2'd2: begin bmag = bus_mag2; bang = bus_ang2; end
		default: begin bmag = bus_mag0; bang = bus_ang0; end
		endcase
	end

	wire [W-1:0] dv = absdiff(bmag, line_side_voltage);
	wire [W-1:0] slip = absdiff(bus_freq, line_freq);
	// Angle in units of 2^W per turn; wrap to shortest distance
	wire [W-1:0] ang_raw = bang - line_ang;
	wire [W-1:0] ang_abs = ang_raw[W-1] ? (~ang_raw + 1'b1) : ang_raw;
	// Lead angle = slip times closing time; scaling left to software units
	wire [2*W-1:0] lead_full = slip * close_t_ff[W-1:0];
	wire [W-1:0] lead = (|lead_full[2*W-1:W]) ? {W{1'b1}} : lead_full[W-1:0];
	// Closing time only counts in machine mode
	wire [W-1:0] lead_used = mode_mach ? lead : {W{1'b0}};
	// Release early while angle closes within lead window
	wire [W:0]   ang_win = {1'b0, dp_lim_ff[W-1:0]} + {1'b0, lead_used};
	wire         ang_ok = {1'b0, ang_abs} <= ang_win;
	wire         sync_now = ctrl_ff[`SCRL_CTRL_EN] & (dv <= dv_lim_ff[W-1:0]) & (slip <= df_lim_ff[W-1:0])
	                        & ang_ok;

	wire bus_live  = bmag >= live_lim_ff[W-1:0];
	wire bus_dead  = bmag <= dead_lim_ff[W-1:0];
	wire line_live = line_side_voltage >= live_lim_ff[W-1:0];
	wire line_dead = line_side_voltage <= dead_lim_ff[W-1:0];
	wire ovr_now = (ctrl_ff[`SCRL_CTRL_LIVE_BUS_DEAD_LINE_EN] & bus_live & line_dead)
	             | (ctrl_ff[`SCRL_CTRL_DEAD_BUS_LIVE_LINE_EN] & bus_dead & line_live)
	             | (ctrl_ff[`SCRL_CTRL_DEAD_BUS_DEAD_LINE_EN] & bus_dead & line_dead);

	// Unsupervised request kinds pass without the check
	wire req_sup = (manual_close_req & ctrl_ff[`SCRL_CTRL_SUP_MAN]) | (auto_close_req & ctrl_ff[`SCRL_CTRL_SUP_AUTO]);
	wire req_free = (manual_close_req & ~ctrl_ff[`SCRL_CTRL_SUP_MAN]) | (auto_close_req & ~ctrl_ff[`SCRL_CTRL_SUP_AUTO]);
	// Bypass holder vouches for synchronism itself
	wire rel_now = req_free | byp_st_ff | (req_sup & (sync_now | ovr_now));

	wire [3:0] evt = {ovr_now & ~ovr_prev_ff, byp_st_ff & ~byp_prev_ff,
	                  rel_now & ~rel_prev_ff, sync_now & ~sync_prev_ff};
	wire stat_rd = reg_rd & (reg_addr == `SCRL_ADDR_IRQ_STAT);
	assign irq = |(irq_stat_ff & irq_mask_ff);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byp_ff        <= 3'b000;
			byp_st_ff     <= 1'b0;
			sync_prev_ff  <= 1'b0;
			rel_prev_ff   <= 1'b0;
			byp_prev_ff   <= 1'b0;
			ovr_prev_ff   <= 1'b0;
			sync_ok       <= 1'b0;
			close_release <= 1'b0;
			irq_stat_ff   <= 4'h0;
		end else begin
			byp_ff <= {byp_ff[1:0], ext_bypass_pin};
			if (byp_ff[1] == byp_ff[2])
				byp_st_ff <= byp_ff[2];
			sync_prev_ff  <= sync_now;
			rel_prev_ff   <= rel_now;
			byp_prev_ff   <= byp_st_ff;
			ovr_prev_ff   <= ovr_now;
			sync_ok       <= sync_now;
			close_release <= rel_now;
			// New events win over the read clear
			irq_stat_ff <= (stat_rd ? 4'h0 : irq_stat_ff) | evt;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff     <= `SCRL_CTRL_RESET;
			dv_lim_ff   <= 16'h0000;
			df_lim_ff   <= 16'h0000;
			dp_lim_ff   <= 16'h0000;
			close_t_ff  <= 16'h0000;
			live_lim_ff <= 16'hFFFF;
			dead_lim_ff <= 16'h0000;
			irq_mask_ff <= 4'h0;
			reg_rdata   <= 16'h0000;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
				`SCRL_ADDR_CTRL:     ctrl_ff     <= reg_wdata;
				`SCRL_ADDR_DV_LIM:   dv_lim_ff   <= reg_wdata;
				`SCRL_ADDR_DF_LIM:   df_lim_ff   <= reg_wdata;
				`SCRL_ADDR_DP_LIM:   dp_lim_ff   <= reg_wdata;
				`SCRL_ADDR_CLOSE_T:  close_t_ff  <= reg_wdata;
				`SCRL_ADDR_LIVE_LIM: live_lim_ff <= reg_wdata;
				`SCRL_ADDR_DEAD_LIM: dead_lim_ff <= reg_wdata;
				`SCRL_ADDR_IRQ_MASK: irq_mask_ff <= reg_wdata[3:0];
				default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				`SCRL_ADDR_CTRL:     reg_rdata <= ctrl_ff;
				`SCRL_ADDR_DV_LIM:   reg_rdata <= dv_lim_ff;
				`SCRL_ADDR_DF_LIM:   reg_rdata <= df_lim_ff;
				`SCRL_ADDR_DP_LIM:   reg_rdata <= dp_lim_ff;
				`SCRL_ADDR_CLOSE_T:  reg_rdata <= close_t_ff;
				`SCRL_ADDR_LIVE_LIM: reg_rdata <= live_lim_ff;
				`SCRL_ADDR_DEAD_LIM: reg_rdata <= dead_lim_ff;
				`SCRL_ADDR_STATUS:   reg_rdata <= {11'h000, ovr_now, byp_st_ff, close_release, sync_ok, mode_mach};
				`SCRL_ADDR_IRQ_STAT: reg_rdata <= {12'h000, irq_stat_ff};
				`SCRL_ADDR_IRQ_MASK: reg_rdata <= {12'h000, irq_mask_ff};
				default:             reg_rdata <= 16'h0000;
				endcase
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end
endmodule

// [scrl_top_tb.sv]
// Directed register level tests of the synchrocheck release block
`timescale 1ns/1ps
module scrl_top_tb;
	logic clk = 0, rst_b = 0, wr = 0, rd = 0, man = 0, aut = 0, byp = 0;
	logic [3:0] ad = 0;
	logic [15:0] wd = 0, bm = 0, bm1 = 0, ba = 0, bf = 16'h03e8, v = 0, f = 16'h03ed, a = 0;
	wire [15:0] rdata, lv, lf, la;
	wire cr, so, irq;
	int fail_count = 0, comparisons = 0, cyc = 0;
	scrl_line u_line (.v(v), .f(f), .a(a), .lv(lv), .lf(lf), .la(la));
	scrl_top dut (.clk(clk), .rst_b(rst_b), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .bus_mag0(bm), .bus_mag1(bm1), .bus_mag2(bm), .bus_ang0(ba), .bus_ang1(ba),
		.bus_ang2(ba), .bus_freq(bf), .line_side_voltage(lv), .line_ang(la), .line_freq(lf),
		.manual_close_req(man), .auto_close_req(aut), .ext_bypass_pin(byp), .close_release(cr),
		.sync_ok(so), .irq(irq));
	task automatic chk(input string n, input [15:0] e, input [15:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wrr(input [3:0] a_i, input [15:0] d);
		@(posedge clk);
		ad <= a_i;
		wd <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rdc(input string n, input [3:0] a_i, input [15:0] e);
		@(posedge clk);
		ad <= a_i;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		@(negedge clk);
		chk(n, e, rdata);
		@(posedge clk);
	endtask
	// Bypass pin needs its synchroniser to settle first
	task automatic st(input string n, input [15:0] e);
		repeat (6) @(posedge clk);
		rdc(n, 4'h7, e);
		chk({n, "_close_release"}, {15'h0000, e[2]}, {15'h0000, cr});
		chk({n, "_sync_ok"}, {15'h0000, e[1]}, {15'h0000, so});
	endtask
	task automatic summarize();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (++cyc == 3000) begin
		fail_count++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1;
		repeat (3) @(posedge clk);
		rdc("ctrl", 4'h0, 16'h0000);
		rdc("unmapped", 4'hf, 16'h0000);
		wrr(4'h0, 16'h0001);
		aut <= 1;
		st("free", 16'h0004);
		aut <= 0;
		man <= 1;
		wrr(4'h0, 16'h0005);
		st("supervised", 16'h0000);
		wrr(4'h2, 16'h000a);
		st("slip", 16'h0006);
		f <= 16'h03e3;
		st("slip_neg", 16'h0006);
		v <= 16'h0010;
		st("mag", 16'h0000);
		wrr(4'h1, 16'h0020);
		a <= 16'h0040;
		wrr(4'h3, 16'h0020);
		st("angle", 16'h0000);
		wrr(4'h0, 16'h0007);
		st("mode", 16'h0001);
		wrr(4'h4, 16'h0008);
		st("lead", 16'h0007);
		wrr(4'h0, 16'h0005);
		st("grid", 16'h0000);
		wrr(4'h5, 16'h0064);
		wrr(4'h6, 16'h0005);
		for (int i = 0; i < 3; i++) begin
			bm <= i ? 16'h0000 : 16'h00c8;
			v <= i == 1 ? 16'h00c8 : 16'h0000;
			wrr(4'h0, 16'h0005 | (16'h0010 << i));
			st("override", 16'h0014);
		end
		// Phase one dead while phase zero live: selection must matter
		bm <= 16'h00c8;
		bm1 <= 16'h0000;
		v <= 16'h0000;
		wrr(4'h0, 16'h0095);
		st("phase_sel", 16'h0000);
		wrr(4'h0, 16'h0005);
		byp <= 1;
		st("bypass", 16'h000c);
		chk("irq_masked", 16'h0000, {15'h0000, irq});
		wrr(4'h9, 16'h0002);
		@(negedge clk);
		chk("irq_on", 16'h0001, {15'h0000, irq});
		rdc("irq_stat", 4'h8, 16'h000f);
		rdc("irq_clr", 4'h8, 16'h0000);
		summarize();
	end
endmodule
